//--- logic/rif_pkg.sv
// shared constants for the reader interrupt flag and enable block
package rif_pkg;

	localparam int unsigned DATA_W = 32;
	localparam int unsigned IDX_W = 8;
	localparam int unsigned ADDR_W = IDX_W + 2;
	localparam int unsigned STRB_W = DATA_W / 8;
	localparam int unsigned REG_W = 8;
	localparam int unsigned FIFO_CNT_W = 5;

	// register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_EN1 = 8'h35;
	localparam logic [IDX_W-1:0] IDX_EN2 = 8'h36;
	localparam logic [IDX_W-1:0] IDX_FLG1 = 8'h37;
	localparam logic [IDX_W-1:0] IDX_FLG2 = 8'h38;
	localparam logic [IDX_W-1:0] IDX_CLR1 = 8'h3C;
	localparam logic [IDX_W-1:0] IDX_CLR2 = 8'h3D;

	// reset values and register bit masks
	localparam logic [REG_W-1:0] EN1_RST = 8'hF7;
	localparam logic [REG_W-1:0] EN2_RST = 8'h40;
	localparam logic [REG_W-1:0] FLG_RST = 8'h00;
	localparam logic [REG_W-1:0] EN2_RSVD_MASK = 8'h38;
	localparam logic [REG_W-1:0] FLG2_USED_MASK = 8'hC7;

	// primary flag and primary enable bit positions
	localparam int unsigned F1_TX = 7;
	localparam int unsigned F1_RX = 6;
	localparam int unsigned F1_FIFO = 5;
	localparam int unsigned F1_ERR = 4;
	localparam int unsigned F1_HDR = 3;
	localparam int unsigned F1_ACK = 1;
	localparam int unsigned F1_NORESP = 0;

	// secondary flag and secondary enable bit positions
	localparam int unsigned F2_ANA = 7;
	localparam int unsigned F2_CMD = 6;
	localparam int unsigned F2_CRC = 2;
	localparam int unsigned F2_LEN = 1;
	localparam int unsigned F2_PRE = 0;

	// fifo fill thresholds in bytes
	localparam logic [FIFO_CNT_W-1:0] FIFO_TX_LOW = 5'h06;
	localparam logic [FIFO_CNT_W-1:0] FIFO_RX_HIGH = 5'h12;
	localparam logic [FIFO_CNT_W-1:0] SECOND_BYTE_CNT = 5'h02;

	function automatic logic [ADDR_W-1:0] rif_byte_addr(input logic [IDX_W-1:0] idx);
		return {idx, 2'b00};
	endfunction : rif_byte_addr

endpackage : rif_pkg

//--- logic/rif_sync2.sv
// two-stage synchroniser for a pin level
`timescale 1ns/1ps
module rif_sync2 (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic async_in,
	output logic sync_out
);
	import rif_pkg::*;

	typedef struct packed {
		logic meta;
		logic stable;
	} rif_sync_t;

	rif_sync_t s_q;
	rif_sync_t s_d;

	always_comb begin
		s_d.meta = async_in;
		s_d.stable = s_q.meta;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sync_out = s_q.stable;
endmodule : rif_sync2

//--- logic/rif_rise_det.sv
// rising-edge detector for a vector of same-clock levels
`timescale 1ns/1ps
module rif_rise_det #(
	parameter int unsigned W = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] lvl,
	output logic [W-1:0] rise
);
	import rif_pkg::*;

	typedef struct packed {
		logic [W-1:0] prev;
	} rif_rise_t;

	rif_rise_t s_q;
	rif_rise_t s_d;

	always_comb begin
		s_d.prev = lvl;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rise = lvl & ~s_q.prev;
endmodule : rif_rise_det

//--- logic/rif_irq_top.sv
// interrupt flag and enable registers with apb slave and irq pin
`timescale 1ns/1ps
module rif_irq_top (
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rif_pkg::ADDR_W-1:0] paddr,
	input wire logic [rif_pkg::DATA_W-1:0] pwdata,
	input wire logic [rif_pkg::STRB_W-1:0] pstrb,
	output logic [rif_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// chip enable pin, not synchronous to pclk
	input wire logic chip_en_pin,
	// events and levels from the transmit, receive and fifo logic
	input wire logic tx_done,
	input wire logic rx_done,
	input wire logic tx_active,
	input wire logic rx_active,
	input wire logic [rif_pkg::FIFO_CNT_W-1:0] fifo_count,
	input wire logic header_bit,
	input wire logic direct_fifo_mode,
	// error pulses
	input wire logic crc_error,
	input wire logic length_error,
	input wire logic preamble_overflow,
	// auto acknowledge sequencer
	input wire logic autoack_active,
	input wire logic autoack_ack_sent,
	input wire logic autoack_success,
	input wire logic noresp_expire,
	// analog status levels and command end
	input wire logic osc_ok,
	input wire logic pll_ok,
	input wire logic rf_ok,
	input wire logic cmd_done,
	// interrupt pin and receive abort request
	output logic irq,
	output logic rx_abort
);
	import rif_pkg::*;

	// true when the bus address selects the register at this index
	function automatic logic reg_sel(
		input logic [ADDR_W-1:0] addr,
		input logic [IDX_W-1:0] idx
	);
		return addr == rif_byte_addr(idx);
	endfunction : reg_sel

	// any set flag whose enable is one requests the pin
	function automatic logic pending(
		input logic [REG_W-1:0] flags,
		input logic [REG_W-1:0] en
	);
		return |(flags & en);
	endfunction : pending

	typedef struct packed {
		logic [DATA_W-1:0] prdata;
		logic pready;
		logic pslverr;
		logic [REG_W-1:0] en1;
		logic [REG_W-1:0] en2;
		logic [REG_W-1:0] flg1;
		logic [REG_W-1:0] flg2;
		logic irq;
		logic rx_abort;
		logic ack_sent;
		logic ana_armed;
		logic [2:0] ana_prev;
	} rif_state_t;

	rif_state_t s_q;
	rif_state_t s_d;

	logic chip_en;
	logic fifo_level_cond;
	logic second_byte_cond;
	logic fifo_level_rise;
	logic second_byte_rise;

	rif_sync2 u_en_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(chip_en_pin),
		.sync_out(chip_en)
	);

	always_comb begin
		fifo_level_cond = 1'b0;
		if (tx_active && (fifo_count < FIFO_TX_LOW)) begin
			fifo_level_cond = 1'b1;
		end
		if (rx_active && (fifo_count > FIFO_RX_HIGH)) begin
			fifo_level_cond = 1'b1;
		end
		second_byte_cond = rx_active && direct_fifo_mode && (fifo_count >= SECOND_BYTE_CNT);
	end

	rif_rise_det #(
		.W(2)
	) u_rise (
		.pclk(pclk),
		.presetn(presetn),
		.lvl({fifo_level_cond, second_byte_cond}),
		.rise({fifo_level_rise, second_byte_rise})
	);

	// bus decode
	logic access;
	logic done;
	logic hit;
	logic wr_ok;
	logic [REG_W-1:0] rd_val;
	logic wr_en1;
	logic wr_en2;
	logic wr_clr1;
	logic wr_clr2;
	logic rd_flg1;
	logic rd_flg2;

	always_comb begin
		access = psel && penable;
		done = access && s_q.pready;
		wr_ok = done && pwrite && pstrb[0] && !s_q.pslverr;
		hit = 1'b1;
		rd_val = 8'h00;
		case (paddr)
			rif_byte_addr(IDX_EN1): begin
				rd_val = s_q.en1;
			end
			rif_byte_addr(IDX_EN2): begin
				rd_val = s_q.en2;
			end
			rif_byte_addr(IDX_FLG1): begin
				rd_val = s_q.flg1;
			end
			rif_byte_addr(IDX_FLG2): begin
				rd_val = s_q.flg2;
			end
			rif_byte_addr(IDX_CLR1): begin
				rd_val = 8'h00;
			end
			rif_byte_addr(IDX_CLR2): begin
				rd_val = 8'h00;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		wr_en1 = wr_ok && reg_sel(paddr, IDX_EN1);
		wr_en2 = wr_ok && reg_sel(paddr, IDX_EN2);
		wr_clr1 = wr_ok && reg_sel(paddr, IDX_CLR1);
		wr_clr2 = wr_ok && reg_sel(paddr, IDX_CLR2);
		rd_flg1 = done && !pwrite && reg_sel(paddr, IDX_FLG1);
		rd_flg2 = done && !pwrite && reg_sel(paddr, IDX_FLG2);
	end

	// event sources
	logic any_error;
	logic rx_failed;
	logic ana_change;
	logic [REG_W-1:0] set1;
	logic [REG_W-1:0] set2;
	logic [REG_W-1:0] clr1;
	logic [REG_W-1:0] clr2;
	logic second_byte_flag;
	logic auto_acknowledge_done_flag;
	logic [2:0] ana_now;

	always_comb begin
		any_error = crc_error || length_error || preamble_overflow;
		rx_failed = noresp_expire || any_error;
		ana_now = {osc_ok, pll_ok, rf_ok};
		// a change in either direction of any analog level counts
		ana_change = s_q.ana_armed && (s_q.ana_prev != ana_now);
		second_byte_flag = direct_fifo_mode ? second_byte_rise : header_bit;
		auto_acknowledge_done_flag = autoack_active
			&& (autoack_success || (s_q.ack_sent && rx_failed));
	end

	// sets ignore the enables; enables steer the pin, and en1 bit F1_NORESP also gates rx_abort
	always_comb begin
		set1 = '0;
		set1[F1_TX] = tx_done;
		set1[F1_RX] = rx_done;
		set1[F1_FIFO] = fifo_level_rise;
		set1[F1_ERR] = any_error;
		set1[F1_HDR] = second_byte_flag;
		set1[F1_ACK] = auto_acknowledge_done_flag;
		set1[F1_NORESP] = noresp_expire;

		set2 = '0;
		set2[F2_ANA] = ana_change;
		set2[F2_CMD] = cmd_done;
		set2[F2_CRC] = crc_error;
		set2[F2_LEN] = length_error;
		set2[F2_PRE] = preamble_overflow;
	end

	// a read clears only the bits that it returned, so a flag set while
	// the read was in flight is kept for the next read
	always_comb begin
		clr1 = '0;
		if (rd_flg1) begin
			clr1 = s_q.prdata[REG_W-1:0];
		end
		if (wr_clr1) begin
			clr1 = clr1 | pwdata[REG_W-1:0];
		end
		clr2 = '0;
		if (rd_flg2) begin
			clr2 = s_q.prdata[REG_W-1:0];
		end
		if (wr_clr2) begin
			clr2 = clr2 | pwdata[REG_W-1:0];
		end
	end

	// next state
	always_comb begin
		s_d = s_q;
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;

		// one wait state: ready rises in the second access cycle
		if (access && !s_q.pready) begin
			s_d.pready = 1'b1;
			s_d.pslverr = !hit;
			s_d.prdata = {{(DATA_W-REG_W){1'b0}}, rd_val};
		end

		if (wr_en1) begin
			s_d.en1 = pwdata[REG_W-1:0];
		end
		if (wr_en2) begin
			s_d.en2 = pwdata[REG_W-1:0] & ~EN2_RSVD_MASK;
		end

		// set wins over any clear in the same cycle
		s_d.flg1 = (s_q.flg1 & ~clr1) | set1;
		s_d.flg2 = ((s_q.flg2 & ~clr2) | set2) & FLG2_USED_MASK;

		// chip disable holds both flag registers empty
		if (!chip_en) begin
			s_d.flg1 = FLG_RST;
			s_d.flg2 = FLG_RST;
		end

		// remembers that the ACK went out in the current auto acknowledge run
		if (!autoack_active) begin
			s_d.ack_sent = 1'b0;
		end else if (autoack_ack_sent) begin
			s_d.ack_sent = 1'b1;
		end

		// comparison starts one edge after reset, so reset is never a change
		s_d.ana_armed = 1'b1;
		s_d.ana_prev = ana_now;

		// pin follows the new flag values so it rises with the flag
		s_d.irq = pending(s_d.flg1, s_d.en1)
			|| pending(s_d.flg2, s_d.en2 & ~EN2_RSVD_MASK);

		s_d.rx_abort = noresp_expire && s_q.en1[F1_NORESP];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q.prdata <= '0;
			s_q.pready <= 1'b0;
			s_q.pslverr <= 1'b0;
			s_q.en1 <= EN1_RST;
			s_q.en2 <= EN2_RST;
			s_q.flg1 <= FLG_RST;
			s_q.flg2 <= FLG_RST;
			s_q.irq <= 1'b0;
			s_q.rx_abort <= 1'b0;
			s_q.ack_sent <= 1'b0;
			s_q.ana_armed <= 1'b0;
			s_q.ana_prev <= 3'h0;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign irq = s_q.irq;
	assign rx_abort = s_q.rx_abort;
endmodule : rif_irq_top

//--- tb/rif_irq_properties.sv
// assertions on the interrupt flag block ports
`timescale 1ns/1ps
module rif_irq_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rif_pkg::ADDR_W-1:0] paddr,
	input wire logic [rif_pkg::DATA_W-1:0] pwdata,
	input wire logic [rif_pkg::STRB_W-1:0] pstrb,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic chip_en_pin,
	input wire logic tx_done,
	input wire logic noresp_expire,
	input wire logic irq,
	input wire logic rx_abort
);
	import rif_pkg::*;
	logic [7:0] en_q;
	logic [3:0] ce_q;
	// shadow of the primary enables and recent chip enable history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q <= EN1_RST;
			ce_q <= 4'h0;
		end else begin
			ce_q <= {ce_q[2:0], chip_en_pin};
			if (pready && pwrite && pstrb[0] && paddr == {IDX_EN1, 2'h0})
				en_q <= pwdata[7:0];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wait_state_a: assert property (psel && penable && !pready |=> pready)
		else $error("ready late");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
	ready_cause_a: assert property (pready |-> psel && penable && $past(penable))
		else $error("ready without access");
	error_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
	abort_cause_a: assert property (rx_abort |-> $past(noresp_expire) && $past(en_q[0]))
		else $error("abort without cause");
	abort_fire_a: assert property (noresp_expire && en_q[0] && &ce_q |=> rx_abort)
		else $error("abort missing");
	tx_irq_a: assert property (tx_done && en_q[7] && &ce_q |=> irq) else $error("irq missing");
	irq_hold_a: assert property (irq && &ce_q && !psel && !$past(psel) |=> irq)
		else $error("irq dropped");
endmodule : rif_irq_properties
bind rif_irq_top rif_irq_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pstrb, .pready, .pslverr, .chip_en_pin, .tx_done, .noresp_expire, .irq,
	.rx_abort);

//--- tb/rif_host_model.sv
// host model issuing apb register transfers
`timescale 1ns/1ps
module rif_host_model (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [rif_pkg::ADDR_W-1:0] paddr,
	output logic [rif_pkg::DATA_W-1:0] pwdata,
	output logic [rif_pkg::STRB_W-1:0] pstrb,
	input wire logic [rif_pkg::DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	import rif_pkg::*;
	initial begin
		{psel, penable, pwrite} = 3'h0;
		paddr = 10'h000;
		pwdata = 32'h0000_0000;
		pstrb = 4'h0;
	end
	task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d,
		input logic [3:0] s, output logic [7:0] r, output logic err);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {i, 2'h0};
		pwdata <= {24'h0, i == IDX_EN2 ? d & ~EN2_RSVD_MASK : d};
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		r = prdata[7:0];
		err = pslverr;
		{psel, penable} <= 2'h0;
		// released lines stop showing the old transfer
		paddr <= ~paddr;
		pwdata <= ~pwdata;
	endtask : xfer
endmodule : rif_host_model

//--- tb/tb_rif_irq_top.sv
// self-checking bench for the reader interrupt flag block
`timescale 1ns/1ps
module tb_rif_irq_top;
	import rif_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rx_abort, e;
	logic chip_en_pin, tx_active, rx_active, direct_fifo_mode, autoack_active, osc_ok;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata;
	logic [STRB_W-1:0] pstrb;
	logic [FIFO_CNT_W-1:0] fifo_count;
	logic [9:0] ev;
	logic [7:0] v;
	int errors = 0;
	int n_tests = 0;
	int cyc = 0;
	// event index, expected primary flags, expected secondary flags
	localparam logic [19:0] EVT [7] = '{20'h74000, 20'h60800, 20'h51004, 20'h41002,
		20'h31001, 20'h10100, 20'h00040};
	rif_host_model u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
		.pready, .pslverr);
	rif_irq_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .chip_en_pin, .tx_done(ev[8]), .rx_done(ev[7]),
		.tx_active, .rx_active, .fifo_count, .header_bit(ev[6]), .direct_fifo_mode,
		.crc_error(ev[5]), .length_error(ev[4]), .preamble_overflow(ev[3]), .autoack_active,
		.autoack_ack_sent(ev[9]), .autoack_success(ev[2]), .noresp_expire(ev[1]), .osc_ok,
		.pll_ok(1'h1), .rf_ok(1'h1), .cmd_done(ev[0]), .irq, .rx_abort);
	task automatic chk(input string s, input logic [7:0] x, input logic [7:0] g);
		n_tests++;
		if (g !== x) begin
			errors++;
			$display("wrong value %s expected %h seen %h", s, x, g);
		end
	endtask : chk
	task automatic pn(input string s, input logic x, input logic g);
		chk(s, {7'h00, x}, {7'h00, g});
	endtask : pn
	task automatic rd(input logic [7:0] i, input logic [7:0] x);
		u_host.xfer(1'h0, i, 8'h00, 4'hF, v, e);
		chk($sformatf("reg %h", i), x, v);
	endtask : rd
	task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [3:0] s);
		u_host.xfer(1'h1, i, d, s, v, e);
	endtask : wr
	task automatic fire(input int b);
		@(posedge pclk);
		ev[b] <= 1'h1;
		@(posedge pclk);
		ev <= 10'h000;
		@(negedge pclk);
	endtask : fire
	task automatic irqis(input logic x);
		repeat (2) @(negedge pclk);
		pn("irq", x, irq);
	endtask : irqis
	task automatic fl(input logic [2:0] m, input logic [4:0] c, input logic [7:0] x);
		@(posedge pclk);
		{tx_active, rx_active, direct_fifo_mode, fifo_count} <= {m, c};
		repeat (2) @(posedge pclk);
		rd(IDX_FLG1, x);
	endtask : fl
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	initial begin
		pclk = 1'h0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			give_verdict();
		end
	end
	initial begin
		presetn = 1'h0;
		{chip_en_pin, osc_ok, tx_active, rx_active, direct_fifo_mode, autoack_active} = 6'h30;
		fifo_count = 5'h00;
		ev = 10'h000;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		rd(IDX_EN1, 8'hF7);
		rd(IDX_EN2, 8'h40);
		rd(IDX_FLG1, 8'h00);
		fire(8);
		pn("irq", 1'h1, irq);
		rd(IDX_FLG1, 8'h80);
		irqis(1'h0);
		foreach (EVT[k]) begin
			fire(EVT[k][19:16]);
			pn("abort", EVT[k][19:16] == 4'h1, rx_abort);
			rd(IDX_FLG1, EVT[k][15:8]);
			rd(IDX_FLG2, EVT[k][7:0]);
		end
		@(posedge pclk);
		osc_ok <= 1'h0;
		rd(IDX_FLG2, 8'h80);
		wr(IDX_EN1, 8'h00, 4'hF);
		wr(IDX_EN2, 8'hFF, 4'hF);
		rd(IDX_EN2, 8'hC7);
		fire(1);
		pn("abort", 1'h0, rx_abort);
		fire(8);
		irqis(1'h0);
		fire(5);
		irqis(1'h1);
		rd(IDX_FLG1, 8'h91);
		irqis(1'h1);
		rd(IDX_FLG2, 8'h04);
		irqis(1'h0);
		fire(7);
		@(posedge pclk);
		chip_en_pin <= 1'h0;
		repeat (4) @(posedge pclk);
		chip_en_pin <= 1'h1;
		rd(IDX_FLG1, 8'h00);
		wr(IDX_EN1, 8'hFF, 4'h0);
		rd(IDX_EN1, 8'h00);
		u_host.xfer(1'h0, 8'h10, 8'h00, 4'hF, v, e);
		pn("slverr", 1'h1, e);
		wr(IDX_EN1, 8'hFF, 4'hF);
		fire(8);
		fire(7);
		wr(IDX_CLR1, 8'h80, 4'hF);
		rd(IDX_FLG1, 8'h40);
		fl(3'h4, 5'h06, 8'h00);
		fl(3'h4, 5'h05, 8'h20);
		fl(3'h2, 5'h12, 8'h00);
		fl(3'h2, 5'h13, 8'h20);
		fl(3'h3, 5'h01, 8'h00);
		fl(3'h3, 5'h02, 8'h08);
		fl(3'h0, 5'h00, 8'h00);
		@(posedge pclk);
		autoack_active <= 1'h1;
		fire(2);
		rd(IDX_FLG1, 8'h02);
		fire(1);
		rd(IDX_FLG1, 8'h01);
		fire(9);
		fire(5);
		rd(IDX_FLG1, 8'h12);
		rd(IDX_FLG2, 8'h04);
		fire(1);
		rd(IDX_FLG1, 8'h03);
		fork
			rd(IDX_FLG1, 8'h00);
			begin
				repeat (3) @(posedge pclk);
				ev[8] <= 1'h1;
				@(posedge pclk);
				ev[8] <= 1'h0;
			end
		join
		rd(IDX_FLG1, 8'h80);
		// event sampled at the edge that captures the read data
		fork
			rd(IDX_FLG1, 8'h00);
			begin
				repeat (2) @(posedge pclk);
				ev[8] <= 1'h1;
				@(posedge pclk);
				ev[8] <= 1'h0;
			end
		join
		rd(IDX_FLG1, 8'h80);
		give_verdict();
	end
endmodule : tb_rif_irq_top
